// ---- hw/rail_fault_cfg.svh ----
// Contract
// - Ten channels: five dedicated, five dual-function.
// - Dual channel is analog or logic, never both.
// - Per channel under, over or window fault.
// - Limits are 8-bit codes, span over 255.
// - Four ranges with fixed bottom and span.
// - Range choice restricted per channel kind.
// - Both comparisons run every cycle always.
// - Under fault clears above limit plus hysteresis.
// - Over fault clears below limit minus hysteresis.
// - Hysteresis is 5-bit code, max 31.
// - Glitch filter is last stage per channel.
// - Filter timeout programmable zero to 100 us.
// - Pulses shorter than timeout never appear.
// - Longer pulses pass, delayed by timeout.
`ifndef RAIL_FAULT_CFG_SVH
`define RAIL_FAULT_CFG_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RF_CH_STRIDE 12'h040
`define RF_OFS_LIMITS 12'h000
`define RF_OFS_CTRL 12'h004
`define RF_OFS_GLITCH 12'h008
`define RF_OFS_STATUS 12'h00C
`define RF_OFS_MEAS 12'h010
`define RF_OFS_SUMMARY 12'h280
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RF_CTRL_MODE_LSB 0
`define RF_CTRL_RANGE_LSB 2
`define RF_CTRL_DIGITAL_BIT 4
`define RF_CTRL_HYST_LSB 8
`define RF_LIMITS_RST 32'h0000_FF00
`define RF_CTRL_RST 32'h0000_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define RF_CLK_MHZ 100
`define RF_GLITCH_MAX_US 100
`define RF_GLITCH_MAX_CYC (`RF_GLITCH_MAX_US * `RF_CLK_MHZ)
`endif

// ---- hw/rail_fault_detector.sv ----
// The placing of the registers and the APB interface to the registers were decided locally.
`include "rail_fault_cfg.svh"
`default_nettype none
module rail_fault_detector
  import rail_fault_pkg::*;
#(
  parameter int NUM_CH = 10,
  parameter int GLITCH_MAX_CYC = `RF_GLITCH_MAX_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end: measured codes, one byte per channel
  input wire logic [NUM_CH*8-1:0] meas_code,
  // Dual-function logic inputs (pins, asynchronous)
  input wire logic [4:0] dual_pin,
  // Towards sequencing engine
  output logic [NUM_CH-1:0] rail_fault,
  output logic [4:0] dual_logic_level
);

  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  // Channel 0 high voltage, 1..4 positive, 5..9 dual-function
  logic [7:0] under_lim_q [NUM_CH];
  logic [7:0] over_lim_q [NUM_CH];
  fault_mode_t mode_q [NUM_CH];
  range_sel_t range_q [NUM_CH];
  logic digital_q [NUM_CH];
  logic [4:0] hyst_q [NUM_CH];
  logic [13:0] glitch_q [NUM_CH];
  chan_status_t stat [NUM_CH];
  logic [7:0] meas_q [NUM_CH];

  // APB address decode
  logic [3:0] ch_idx;
  logic [5:0] ch_ofs;
  logic ch_hit;
  logic sum_hit;
  logic wr_en;
  assign ch_idx = paddr[9:6];
  assign ch_ofs = paddr[5:0];
  assign ch_hit = (paddr[11:10] == 2'b00) && (ch_idx < 4'(NUM_CH));
  assign sum_hit = (paddr == `RF_OFS_SUMMARY);
  assign wr_en = psel && penable && pwrite;
  // Single-cycle access phase keeps the master timing simple
  assign pready = 1'b1;
  assign pslverr = psel && penable && !ch_hit && !sum_hit;

  // Range legality: clamp an illegal request to the nearest allowed range
  function automatic range_sel_t legal_range(input int ch, input logic [1:0] req);
    range_sel_t r;
    r = range_sel_t'(req);
    if (ch == 0) begin
      if (req < 2'd2) begin
        r = range_2v5;
      end
    end else if (ch < 5) begin
      if (req == 2'd3) begin
        r = range_2v5;
      end
    end else begin
      r = range_0v573;
    end
    return r;
  endfunction : legal_range

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Configuration per channel, written on the APB access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        under_lim_q[i] <= 8'(`RF_LIMITS_RST);
        over_lim_q[i] <= 8'(`RF_LIMITS_RST >> 8);
        mode_q[i] <= mode_under;
        range_q[i] <= (i == 0) ? range_2v5 : ((i < 5) ? range_1v25 : range_0v573);
        digital_q[i] <= 1'b0;
        hyst_q[i] <= 5'h00;
      end
    end else if (wr_en && ch_hit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_idx == 4'(i)) begin
          case (ch_ofs)
            6'(`RF_OFS_LIMITS): begin
              under_lim_q[i] <= pwdata[7:0];
              over_lim_q[i] <= pwdata[15:8];
            end
            6'(`RF_OFS_CTRL): begin
              mode_q[i] <= fault_mode_t'(pwdata[`RF_CTRL_MODE_LSB +: 2]);
              range_q[i] <= legal_range(i, pwdata[`RF_CTRL_RANGE_LSB +: 2]);
              // Only dual-function channels can become logic inputs
              digital_q[i] <= (i >= 5) ? pwdata[`RF_CTRL_DIGITAL_BIT] : 1'b0;
              hyst_q[i] <= pwdata[`RF_CTRL_HYST_LSB +: 5];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Glitch timeout per channel; longer requests saturate at the maximum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        glitch_q[i] <= 14'h0000;
      end
    end else if (wr_en && ch_hit && (ch_ofs == 6'(`RF_OFS_GLITCH))) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_idx == 4'(i)) begin
          if (pwdata[15:0] > 16'(GLITCH_MAX_CYC)) begin
            glitch_q[i] <= 14'(GLITCH_MAX_CYC);
          end else begin
            glitch_q[i] <= pwdata[13:0];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Decode of the read word; unmapped reads return zero
  logic [31:0] prdata_d;
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (sum_hit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        prdata_d[i] = stat[i].filtered_fault;
      end
    end else if (ch_hit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_idx == 4'(i)) begin
          case (ch_ofs)
            6'(`RF_OFS_LIMITS): prdata_d = {16'h0000, over_lim_q[i], under_lim_q[i]};
            6'(`RF_OFS_CTRL): prdata_d = {19'h0, hyst_q[i], 3'b000, digital_q[i],
                                          range_q[i], mode_q[i]};
            6'(`RF_OFS_GLITCH): prdata_d = {18'h0, glitch_q[i]};
            6'(`RF_OFS_STATUS): prdata_d = {28'h0, stat[i]};
            6'(`RF_OFS_MEAS): prdata_d = {24'h0, meas_q[i]};
            default: prdata_d = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Latched in the setup phase, while the address is already stable, so the
  // access phase reads a flip-flop; status is then one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= prdata_d;
    end
  end

  // ----------------------------------------
  // Front-end sampling
  // ----------------------------------------
  // Measured codes come from the converter on this clock, so no synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        meas_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        meas_q[i] <= meas_code[i*8 +: 8];
      end
    end
  end

  // Dual-function pins are asynchronous: three stages, accept on agreement
  logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
      pin_lvl_q <= 5'h00;
    end else begin
      pin_s1_q <= dual_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int k = 0; k < 5; k++) begin
        if (pin_s2_q[k] == pin_s3_q[k]) begin
          pin_lvl_q[k] <= pin_s2_q[k];
        end
      end
    end
  end

  // Logic level reads zero while the channel supervises a rail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_logic_level <= 5'h00;
    end else begin
      for (int k = 0; k < 5; k++) begin
        dual_logic_level[k] <= digital_q[k+5] && pin_lvl_q[k];
      end
    end
  end

  // ----------------------------------------
  // Comparators with hysteresis
  // ----------------------------------------
  // Codes share one scale per range, so hysteresis adds directly in code units
  logic under_q [NUM_CH];
  logic over_q [NUM_CH];
  logic raw_fault [NUM_CH];
  // Under-limit side, tracked every cycle whatever the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        under_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!under_q[i]) begin
          under_q[i] <= meas_q[i] < under_lim_q[i];
        end else begin
          // Held until the code rises strictly above limit plus hysteresis
          under_q[i] <= 9'(meas_q[i]) <= 9'(under_lim_q[i]) + 9'(hyst_q[i]);
        end
      end
    end
  end

  // Over-limit side, also tracked every cycle, so a mode change finds it current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        over_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!over_q[i]) begin
          over_q[i] <= meas_q[i] > over_lim_q[i];
        end else begin
          // Signed compare so a limit below the hysteresis never wraps
          over_q[i] <= $signed({1'b0, meas_q[i]}) >=
                       $signed({1'b0, over_lim_q[i]}) - $signed({4'h0, hyst_q[i]});
        end
      end
    end
  end

  // Fault type selection ahead of the filter
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      case (mode_q[i])
        mode_under: raw_fault[i] = under_q[i];
        mode_over: raw_fault[i] = over_q[i];
        mode_window: raw_fault[i] = under_q[i] || over_q[i];
        default: raw_fault[i] = 1'b0;
      endcase
      if (digital_q[i]) begin
        raw_fault[i] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Glitch filters
  // ----------------------------------------
  // Each edge must persist for the timeout before the output follows it,
  // so short pulses vanish and long ones emerge delayed by that timeout
  gf_state_t gf_q [NUM_CH];
  logic [13:0] gf_cnt_q [NUM_CH];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        gf_q[i] <= gf_idle;
        gf_cnt_q[i] <= 14'h0000;
        rail_fault[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        case (gf_q[i])
          gf_idle: begin
            gf_cnt_q[i] <= 14'h0000;
            if (raw_fault[i]) begin
              if (glitch_q[i] == 14'h0000) begin
                gf_q[i] <= gf_high;
                rail_fault[i] <= 1'b1;
              end else begin
                gf_q[i] <= gf_rise;
                gf_cnt_q[i] <= 14'h0001;
              end
            end
          end
          gf_rise: begin
            if (!raw_fault[i]) begin
              gf_q[i] <= gf_idle;
            end else if (gf_cnt_q[i] >= glitch_q[i]) begin
              gf_q[i] <= gf_high;
              rail_fault[i] <= 1'b1;
            end else begin
              gf_cnt_q[i] <= gf_cnt_q[i] + 14'h0001;
            end
          end
          gf_high: begin
            gf_cnt_q[i] <= 14'h0000;
            if (!raw_fault[i]) begin
              if (glitch_q[i] == 14'h0000) begin
                gf_q[i] <= gf_idle;
                rail_fault[i] <= 1'b0;
              end else begin
                gf_q[i] <= gf_fall;
                gf_cnt_q[i] <= 14'h0001;
              end
            end
          end
          gf_fall: begin
            if (raw_fault[i]) begin
              gf_q[i] <= gf_high;
            end else if (gf_cnt_q[i] >= glitch_q[i]) begin
              gf_q[i] <= gf_idle;
              rail_fault[i] <= 1'b0;
            end else begin
              gf_cnt_q[i] <= gf_cnt_q[i] + 14'h0001;
            end
          end
          default: begin
            gf_q[i] <= gf_idle;
          end
        endcase
      end
    end
  end

  // Status bundle for readback
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      stat[i] = '{under_limit_fault: under_q[i], over_limit_fault: over_q[i],
                  raw_fault: raw_fault[i], filtered_fault: rail_fault[i]};
    end
  end

endmodule : rail_fault_detector
`default_nettype wire

// ---- hw/rail_fault_pkg.sv ----
`default_nettype none
package rail_fault_pkg;
  // Fault type selection per channel
  typedef enum logic [1:0] {
    mode_under,
    mode_over,
    mode_window,
    mode_off
  } fault_mode_t;
  // Range selection, lowest to highest
  typedef enum logic [1:0] {
    range_0v573,
    range_1v25,
    range_2v5,
    range_6v0
  } range_sel_t;
  // Per-channel result bundle
  typedef struct packed {
    logic under_limit_fault;
    logic over_limit_fault;
    logic raw_fault;
    logic filtered_fault;
  } chan_status_t;
  // Glitch filter state
  typedef enum logic [1:0] {
    gf_idle,
    gf_rise,
    gf_high,
    gf_fall
  } gf_state_t;
endpackage : rail_fault_pkg
`default_nettype wire

// ---- sim/rail_fault_detector_assertions.sv ----
`default_nettype none
module rail_fault_checker #(
  parameter int NUM_CH = 10,
  parameter int GLITCH_MAX_CYC = 10000
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Front end and results
  input wire logic [NUM_CH*8-1:0] meas_code,
  input wire logic [4:0] dual_pin,
  input wire logic [NUM_CH-1:0] rail_fault,
  input wire logic [4:0] dual_logic_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic [4:0] dig_q;
  logic [15:0] quiet_q;
  logic [1:0] age_q;
  logic [NUM_CH*8-1:0] meas_prev_q;
  assign acc = psel && penable;
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  // Shadow of the digital bits, so no hierarchy is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_q <= '0;
    end else begin
      for (int k = 0; k < 5; k++) begin
        if (acc && pwrite && paddr == 12'(((k + 5) * 64) + 4)) begin
          dig_q[k] <= pwdata[4];
        end
      end
    end
  end
  // Quiet time since the last cause; output may only move while it is short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= '0;
      age_q <= '0;
      meas_prev_q <= '0;
    end else begin
      meas_prev_q <= meas_code;
      quiet_q <= (meas_code != meas_prev_q || (acc && pwrite)) ? 16'h0000 :
                 quiet_q + 16'(quiet_q != 16'hFFFF);
      age_q <= age_q + 2'(age_q != 2'd3);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  pready_always_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (acc && paddr >= 12'h284 |-> pslverr)
    else $error("no slave error");
  mapped_ok_a: assert property (acc && paddr <= 12'h280 |-> !pslverr)
    else $error("false error");
  dual_excl_a: assert property ((dual_logic_level & ~(dig_q | $past(dig_q))) == 5'h00)
    else $error("logic level on analog channel");
  fault_settle_a: assert property (quiet_q > 16'(GLITCH_MAX_CYC + 8) |-> $stable(rail_fault))
    else $error("fault moved without cause");
  summary_read_a: assert property (acc && !pwrite && paddr == 12'h280
    |-> prdata == 32'($past(rail_fault))) else $error("summary mismatch");
  meas_read_a: assert property (acc && !pwrite && paddr == 12'h010
    |-> prdata[7:0] == $past(meas_code[7:0], 2)) else $error("measured code mismatch");
  reset_quiet_a: assert property (age_q < 2'd3 |-> rail_fault == '0)
    else $error("fault too soon after reset");
  cover property (acc && pslverr);
  cover property ($rose(rail_fault[4]));
  cover property ($rose(dual_logic_level[0]));
endmodule : rail_fault_checker
bind rail_fault_detector rail_fault_checker #(.NUM_CH(NUM_CH), .GLITCH_MAX_CYC(GLITCH_MAX_CYC))
  chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
       .pslverr, .meas_code, .dual_pin, .rail_fault, .dual_logic_level);
`default_nettype wire

// ---- sim/rail_fault_detector_test.sv ----
`default_nettype none
module rail_fault_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GMAX = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [79:0] meas_code;
  logic [4:0] dual_pin, dual_logic_level;
  logic [9:0] rail_fault;
  int err_count, cmp_count, cyc;
  logic [11:0] ca [4] = '{12'h004, 12'h044, 12'h144, 12'h004};
  logic [31:0] cw [4] = '{32'h0000_0000, 32'h0000_000C, 32'h0000_000C, 32'h0000_000F};
  logic [31:0] ce [4] = '{32'h0000_0008, 32'h0000_0008, 32'h0000_0000, 32'h0000_000F};
  // Short glitch ceiling keeps the run brief
  rail_fault_detector #(.NUM_CH(10), .GLITCH_MAX_CYC(GMAX)) uut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_code, .dual_pin,
    .rail_fault, .dual_logic_level);
  rail_front_end #(.NUM_CH(10)) fe (.pclk, .meas_code, .dual_pin);
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Idle edge first, so a strobe is never assigned twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk("read", e, rd);
  endtask : rchk
  task automatic fchk(input int ch, input logic e, input int n);
    repeat (n) @(posedge pclk);
    #1 chk("fault", 32'(e), 32'(rail_fault[ch]));
  endtask : fchk
  task automatic step(input int ch, input logic [7:0] c, input logic e);
    fe.set_code(ch, c);
    fchk(ch, e, 5);
  endtask : step
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h000, 32'h0000_FF00);
    rchk(12'h004, 32'h0000_0008);
    rchk(12'h044, 32'h0000_0004);
    rchk(12'h010, 32'h0000_0080);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ca[i], cw[i]);
      rchk(ca[i], ce[i]);
    end
    rchk(12'h400, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, 32'(er));
    $display("test registers done");
    xfer(1'b1, 12'h040, 32'h0000_FF40);
    xfer(1'b1, 12'h044, 32'h0000_0508);
    xfer(1'b1, 12'h048, 32'h0000_0000);
    step(1, 8'h3F, 1'b1);
    step(1, 8'h45, 1'b1);
    step(1, 8'h46, 1'b0);
    xfer(1'b1, 12'h080, 32'h0000_C000);
    xfer(1'b1, 12'h084, 32'h0000_0305);
    xfer(1'b1, 12'h088, 32'h0000_0000);
    step(2, 8'hC1, 1'b1);
    step(2, 8'hBD, 1'b1);
    step(2, 8'hBC, 1'b0);
    $display("test hysteresis done");
    xfer(1'b1, 12'h0C0, 32'h0000_C040);
    xfer(1'b1, 12'h0C4, 32'h0000_0006);
    xfer(1'b1, 12'h0C8, 32'h0000_0000);
    step(3, 8'h3F, 1'b1);
    step(3, 8'h80, 1'b0);
    step(3, 8'hC1, 1'b1);
    step(3, 8'h80, 1'b0);
    xfer(1'b1, 12'h0C4, 32'h0000_0007);
    step(3, 8'h3F, 1'b0);
    $display("test window done");
    xfer(1'b1, 12'h100, 32'h0000_FF40);
    xfer(1'b1, 12'h108, 32'h0000_003C);
    rchk(12'h108, 32'h0000_0032);
    xfer(1'b1, 12'h108, 32'h0000_000A);
    fe.set_code(4, 8'h3F);
    repeat (7) @(posedge pclk);
    fe.set_code(4, 8'h80);
    repeat (20) fchk(4, 1'b0, 1);
    fe.set_code(4, 8'h3F);
    fchk(4, 1'b0, 11);
    fchk(4, 1'b1, 4);
    rchk(12'h10C, 32'h0000_000B);
    rchk(12'h280, 32'h0000_0010);
    fe.set_code(4, 8'h80);
    fchk(4, 1'b1, 11);
    fchk(4, 1'b0, 4);
    $display("test glitch done");
    xfer(1'b1, 12'h140, 32'h0000_FF40);
    xfer(1'b1, 12'h144, 32'h0000_0010);
    fe.set_pin(0, 1'b1);
    step(5, 8'h00, 1'b0);
    chk("level", 32'h0000_0001, 32'(dual_logic_level[0]));
    xfer(1'b1, 12'h144, 32'h0000_0000);
    fchk(5, 1'b1, 5);
    chk("level", 32'h0000_0000, 32'(dual_logic_level[0]));
    $display("test dual done");
    report_and_stop();
  end
endmodule : rail_fault_detector_test
`default_nettype wire

// ---- sim/rail_front_end.sv ----
`default_nettype none
module rail_front_end #(
  parameter int NUM_CH = 10
) (
  // Clock
  input wire logic pclk,
  // Comparator bank and logic pins
  output logic [NUM_CH*8-1:0] meas_code,
  output logic [4:0] dual_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mid-scale rails: neither limit is crossed at power-up
  initial begin
    meas_code = {NUM_CH{8'h80}};
    dual_pin = 5'h00;
  end
  // A rail moves just after an edge, like a sampled comparator bank
  task automatic set_code(input int ch, input logic [7:0] code);
    @(posedge pclk);
    meas_code[ch*8 +: 8] <= code;
  endtask : set_code
  task automatic set_pin(input int k, input logic v);
    @(posedge pclk);
    dual_pin[k] <= v;
  endtask : set_pin
endmodule : rail_front_end
`default_nettype wire
